/* include/rprb_pkg.sv */
// shared constants of the root port bridge control and express capability
package rprb_pkg;
    // configuration byte offsets
    localparam logic [7:0]  OFF_SEC_STATUS  = 8'h1E;
    localparam logic [7:0]  OFF_BRIDGE_CTRL = 8'h3E;
    localparam logic [7:0]  OFF_CAP_ID      = 8'h40;
    localparam logic [7:0]  OFF_NEXT_PTR    = 8'h41;
    localparam logic [7:0]  OFF_EXP_CAPS    = 8'h42;
    // bridge control field positions
    localparam int BC_PARITY_RESP = 0;
    localparam int BC_ERR_FWD     = 1;
    localparam int BC_ISA_BLOCK   = 2;
    localparam int BC_VGA_CLAIM   = 3;
    localparam int BC_VGA_16BIT   = 4;
    localparam int BC_HOT_RESET   = 6;
    localparam logic [15:0] BC_WRITE_MASK  = 16'h005F;
    localparam logic [15:0] BC_RESET       = 16'h0000;
    // secondary status: parity detected bit
    localparam int SS_PARITY_BIT = 8;
    // capability header constants
    localparam logic [7:0]  CAP_ID_VALUE   = 8'h10;
    localparam logic [7:0]  NEXT_PTR_VALUE = 8'h90;
    localparam logic [3:0]  PORT_TYPE_ROOT = 4'h4;
    localparam logic [3:0]  CAP_VERSION    = 4'h1;
    localparam logic [4:0]  MSG_VECTOR_NUM = 5'h00;
    localparam int CAP_SLOT_BIT = 8;
    // legacy decode ranges
    localparam logic [31:0] VGA_MEM_LO   = 32'h000A0000;
    localparam logic [31:0] VGA_MEM_HI   = 32'h000BFFFF;
    localparam logic [9:0]  VGA_IO_A_LO  = 10'h3B0;
    localparam logic [9:0]  VGA_IO_A_HI  = 10'h3BB;
    localparam logic [9:0]  VGA_IO_B_LO  = 10'h3C0;
    localparam logic [9:0]  VGA_IO_B_HI  = 10'h3DF;
    localparam logic [15:0] ISA_REGION_TOP = 16'hFFFF;
    localparam logic [9:0]  ISA_ALIAS_LO   = 10'h100;
endpackage : rprb_pkg

/* include/rprb_ctl_if.sv */
// control bits carried from the register bank to the decode and event logic
`timescale 1ns/1ps
interface rprb_ctl_if;
    logic vga_claim;
    logic vga_16bit;
    logic isa_block;
    logic err_fwd;
    logic parity_resp;
    modport ctl (output vga_claim, vga_16bit, isa_block, err_fwd,
                 parity_resp);
    modport dec (input vga_claim, vga_16bit, isa_block);
    modport evt (input err_fwd, parity_resp);
endinterface : rprb_ctl_if

/* rtl/rprb_decode.sv */
// address decode for legacy graphics claiming and isa alias blocking
`timescale 1ns/1ps
module rprb_decode
    import rprb_pkg::*;
(
    rprb_ctl_if.dec     ctl,
    input  wire logic [31:0] addr,
    input  wire logic        is_io,
    input  wire logic [15:0] io_base,
    input  wire logic [15:0] io_limit,
    output logic             claim,
    output logic             block
);
    // legacy graphics ranges; aliases ignore bits 15:10 unless 16-bit mode
    wire logic upper_zero = (addr[31:16] == 16'h0000);
    wire logic alias_ok   = !ctl.vga_16bit || (addr[15:10] == 6'h00);
    wire logic vga_mem    = !is_io && (addr >= VGA_MEM_LO)
                            && (addr <= VGA_MEM_HI);
    wire logic vga_io_a   = (addr[9:0] >= VGA_IO_A_LO)
                            && (addr[9:0] <= VGA_IO_A_HI);
    wire logic vga_io_b   = (addr[9:0] >= VGA_IO_B_LO)
                            && (addr[9:0] <= VGA_IO_B_HI);
    wire logic vga_io     = is_io && upper_zero && alias_ok
                            && (vga_io_a || vga_io_b);
    assign claim = ctl.vga_claim && (vga_mem || vga_io);

    // isa aliases: top 768 bytes of each 1 KB inside the io window
    wire logic in_window  = (addr[15:0] >= io_base)
                            && (addr[15:0] <= io_limit);
    wire logic low_64k    = upper_zero && (addr[15:0] <= ISA_REGION_TOP);
    wire logic isa_alias  = (addr[9:0] >= ISA_ALIAS_LO);
    assign block = ctl.isa_block && is_io && in_window
                   && low_64k && isa_alias;
endmodule : rprb_decode

/* rtl/rprb_events.sv */
// gating of received error messages and poisoned traffic events
`timescale 1ns/1ps
module rprb_events
    import rprb_pkg::*;
(
    rprb_ctl_if.evt     ctl,
    input  wire logic   err_valid,
    input  wire logic   poison_cpl,
    input  wire logic   poison_wr,
    output logic        err_forward,
    output logic        parity_set
);
    // fatal and non-fatal messages stop here unless forwarding is enabled
    assign err_forward = err_valid && ctl.err_fwd;
    // only a poisoned completion in or a poisoned write out counts
    assign parity_set  = ctl.parity_resp
                         && (poison_cpl || poison_wr);
endmodule : rprb_events

/* rtl/rprb_top.sv */
// root port bridge control, secondary parity flag and capability header
//
// Operation
// - writing one to the hot reset bit starts hot reset on the link
// - graphics claim bit set claims legacy memory and io ranges, aliases too unless 16-bit decode is set
// - isa block bit set refuses io hits in top 768 bytes per 1 KB
// - error forwarding bit gates fatal and non-fatal messages to backbone
// - parity response bit gates poisoned traffic onto the parity flag
// - parity flag is write-one-to-clear, set only on poisoned events
// - byte at 40h reads capability identifier 10h
// - byte at 41h reads next capability pointer 90h
// - slot implemented bit takes one write, held until reset
// - port type field reads 4h for a root port
// - capability version field reads 1h
// - message vector number field reads zero
`timescale 1ns/1ps
module rprb_top
    import rprb_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        CFG_WR,
    input  wire logic        CFG_RD,
    input  wire logic [7:2]  CFG_ADDR,
    input  wire logic [3:0]  CFG_BE,
    input  wire logic [31:0] CFG_WDATA,
    output logic      [31:0] CFG_RDATA,
    output logic             CFG_RVALID,
    output logic             HOT_RESET,
    input  wire logic        TXN_VALID,
    input  wire logic        TXN_IO,
    input  wire logic [31:0] TXN_ADDR,
    input  wire logic [15:0] IO_BASE,
    input  wire logic [15:0] IO_LIMIT,
    output logic             TXN_DONE,
    output logic             TXN_CLAIM,
    output logic             TXN_BLOCK,
    input  wire logic        ERR_MSG_VALID,
    input  wire logic        ERR_MSG_FATAL,
    output logic             ERR_FWD_VALID,
    output logic             ERR_FWD_FATAL,
    input  wire logic        RX_POISON_CPL,
    input  wire logic        TX_POISON_WR,
    output logic             SEC_PARITY_DET
);
    // register state
    logic [15:0] bridge_control_q;
    logic [15:0] bridge_control_d;
    logic        parity_q;
    logic        parity_d;
    logic        slot_q;
    logic        slot_d;
    logic        slot_lock_q;
    logic        slot_lock_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        rvalid_q;
    logic        claim_q;
    logic        block_q;
    logic        done_q;
    logic        fwd_q;
    logic        fwd_fatal_q;

    rprb_ctl_if ctl_if ();

    // dword decode of the configuration address
    wire logic hit_ss  = (CFG_ADDR == OFF_SEC_STATUS[7:2]);
    wire logic hit_bc  = (CFG_ADDR == OFF_BRIDGE_CTRL[7:2]);
    wire logic hit_cap = (CFG_ADDR == OFF_CAP_ID[7:2]);
    wire logic wr_bc_lo  = CFG_WR && hit_bc && CFG_BE[2];
    wire logic wr_ss_hi  = CFG_WR && hit_ss && CFG_BE[3];
    wire logic wr_cap_hi = CFG_WR && hit_cap && CFG_BE[3];
    wire logic [15:0] bc_wdata = CFG_WDATA[31:16];
    wire logic [15:0] ss_wdata = CFG_WDATA[31:16];
    wire logic [15:0] cap_wdata = CFG_WDATA[31:16];

    // control bits handed to the decode and event logic
    assign ctl_if.vga_claim   = bridge_control_q[BC_VGA_CLAIM];
    assign ctl_if.vga_16bit   = bridge_control_q[BC_VGA_16BIT];
    assign ctl_if.isa_block   = bridge_control_q[BC_ISA_BLOCK];
    assign ctl_if.err_fwd     = bridge_control_q[BC_ERR_FWD];
    assign ctl_if.parity_resp = bridge_control_q[BC_PARITY_RESP];

    logic claim_w;
    logic block_w;
    logic fwd_w;
    logic parity_set_w;

    rprb_decode u_decode (
        .ctl      (ctl_if.dec),
        .addr     (TXN_ADDR),
        .is_io    (TXN_IO),
        .io_base  (IO_BASE),
        .io_limit (IO_LIMIT),
        .claim    (claim_w),
        .block    (block_w)
    );

    rprb_events u_events (
        .ctl         (ctl_if.evt),
        .err_valid   (ERR_MSG_VALID),
        .poison_cpl  (RX_POISON_CPL),
        .poison_wr   (TX_POISON_WR),
        .err_forward (fwd_w),
        .parity_set  (parity_set_w)
    );

    // bridge control: only the documented writable bits take data;
    // the upper lane holds nothing writable so lane 3 is ignored
    assign bridge_control_d = wr_bc_lo ? ((bridge_control_q & ~BC_WRITE_MASK)
                     | ({8'h00, bc_wdata[7:0]} & BC_WRITE_MASK))
                     : bridge_control_q;

    // parity flag: a new event wins over a clear in the same cycle
    wire logic parity_clr = wr_ss_hi && ss_wdata[SS_PARITY_BIT];
    assign parity_d = parity_set_w
                      || (parity_q && !parity_clr);

    // slot implemented: first write to its byte locks the value
    wire logic slot_take = wr_cap_hi && !slot_lock_q;
    assign slot_d      = slot_take ? cap_wdata[CAP_SLOT_BIT] : slot_q;
    assign slot_lock_d = slot_lock_q || wr_cap_hi;

    // read words assembled from constants and live state
    wire logic [15:0] caps_word = {2'b00, MSG_VECTOR_NUM, slot_q,
                                   PORT_TYPE_ROOT,
                                   CAP_VERSION};
    wire logic [15:0] ss_word = {7'h00, parity_q, 8'h00};
    always_comb begin
        if (!CFG_RD) begin
            rdata_d = rdata_q;
        end else if (hit_ss) begin
            rdata_d = {ss_word, 16'h0000};
        end else if (hit_bc) begin
            rdata_d = {bridge_control_q, 16'h0000};
        end else if (hit_cap) begin
            rdata_d = {caps_word, NEXT_PTR_VALUE,
                       CAP_ID_VALUE};
        end else begin
            rdata_d = 32'h00000000;  // unmapped dwords read zero
        end
    end

    // register bank flops
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            bridge_control_q     <= BC_RESET;
            parity_q    <= 1'b0;
            slot_q      <= 1'b0;
            slot_lock_q <= 1'b0;
            rdata_q     <= 32'h00000000;
            rvalid_q    <= 1'b0;
        end else begin
            bridge_control_q     <= bridge_control_d;
            parity_q    <= parity_d;
            slot_q      <= slot_d;
            slot_lock_q <= slot_lock_d;
            rdata_q     <= rdata_d;
            rvalid_q    <= CFG_RD;
        end
    end

    // transaction and message results, one cycle behind the request
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            done_q      <= 1'b0;
            claim_q     <= 1'b0;
            block_q     <= 1'b0;
            fwd_q       <= 1'b0;
            fwd_fatal_q <= 1'b0;
        end else begin
            done_q      <= TXN_VALID;
            claim_q     <= TXN_VALID && claim_w;
            block_q     <= TXN_VALID && block_w;
            fwd_q       <= fwd_w;
            fwd_fatal_q <= fwd_w && ERR_MSG_FATAL;
        end
    end

    // hot reset follows the stored bit, so it lasts as long as the bit
    assign HOT_RESET      = bridge_control_q[BC_HOT_RESET];
    assign CFG_RDATA      = rdata_q;
    assign CFG_RVALID     = rvalid_q;
    assign TXN_DONE       = done_q;
    assign TXN_CLAIM      = claim_q;
    assign TXN_BLOCK      = block_q;
    assign ERR_FWD_VALID  = fwd_q;
    assign ERR_FWD_FATAL  = fwd_fatal_q;
    assign SEC_PARITY_DET = parity_q;

    // checks on the register bank and its effects
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    property p_hot_set;
        wr_bc_lo && bc_wdata[BC_HOT_RESET] |=> HOT_RESET;
    endproperty
    a_hot_set: assert property (p_hot_set)
        else $error("hot reset not raised by write");

    property p_hot_hold;
        HOT_RESET && !wr_bc_lo |=> HOT_RESET;
    endproperty
    a_hot_hold: assert property (p_hot_hold)
        else $error("hot reset dropped while bit set");

    property p_hot_clear;
        wr_bc_lo && !bc_wdata[BC_HOT_RESET] |=> !HOT_RESET;
    endproperty
    a_hot_clear: assert property (p_hot_clear)
        else $error("hot reset kept after clear");

    property p_vga_mem;
        TXN_VALID && !TXN_IO && (TXN_ADDR >= VGA_MEM_LO)
            && (TXN_ADDR <= VGA_MEM_HI)
        |=> TXN_CLAIM == $past(bridge_control_q[BC_VGA_CLAIM]);
    endproperty
    a_vga_mem: assert property (p_vga_mem)
        else $error("legacy memory claim wrong");

    property p_isa_off;
        !bridge_control_q[BC_ISA_BLOCK] |=> !TXN_BLOCK;
    endproperty
    a_isa_off: assert property (p_isa_off)
        else $error("io blocked with blocking disabled");

    property p_err_gate;
        ERR_MSG_VALID |=> ERR_FWD_VALID == $past(bridge_control_q[BC_ERR_FWD]);
    endproperty
    a_err_gate: assert property (p_err_gate)
        else $error("error message forwarding wrong");

    property p_par_off;
        !bridge_control_q[BC_PARITY_RESP] && !SEC_PARITY_DET |=> !SEC_PARITY_DET;
    endproperty
    a_par_off: assert property (p_par_off)
        else $error("parity flag set with response off");

    property p_par_set;
        bridge_control_q[BC_PARITY_RESP] && (RX_POISON_CPL || TX_POISON_WR)
        |=> SEC_PARITY_DET;
    endproperty
    a_par_set: assert property (p_par_set)
        else $error("poisoned event lost");

    property p_par_clr;
        SEC_PARITY_DET && parity_clr && !parity_set_w |=> !SEC_PARITY_DET;
    endproperty
    a_par_clr: assert property (p_par_clr)
        else $error("parity flag not cleared by one");

    property p_ro_zero;
        bridge_control_q[15:7] == 9'h000 && !bridge_control_q[5];
    endproperty
    a_ro_zero: assert property (p_ro_zero)
        else $error("read-only bridge bit nonzero");

    property p_cap_hdr;
        CFG_RD && hit_cap |=> CFG_RVALID && CFG_RDATA[15:0] == 16'h9010;
    endproperty
    a_cap_hdr: assert property (p_cap_hdr)
        else $error("capability header read wrong");

    property p_caps_fixed;
        CFG_RD && hit_cap |=> CFG_RDATA[23:16] == 8'h41
            && CFG_RDATA[31:25] == 7'h00;
    endproperty
    a_caps_fixed: assert property (p_caps_fixed)
        else $error("capability fields read wrong");

    property p_slot_once;
        slot_lock_q |=> $stable(slot_q) && slot_lock_q;
    endproperty
    a_slot_once: assert property (p_slot_once)
        else $error("slot bit changed after first write");

    // the first write takes its data and locks, whatever the value
    property p_slot_first;
        wr_cap_hi && !slot_lock_q
        |=> slot_q == $past(cap_wdata[CAP_SLOT_BIT]) && slot_lock_q;
    endproperty
    a_slot_first: assert property (p_slot_first)
        else $error("first slot write not taken");

    property p_vga_off;
        !bridge_control_q[BC_VGA_CLAIM] |=> !TXN_CLAIM;
    endproperty
    a_vga_off: assert property (p_vga_off)
        else $error("legacy range claimed with claiming off");

    // 16-bit mode: io addresses with upper bits set are not aliases
    property p_vga_wide;
        TXN_VALID && TXN_IO && bridge_control_q[BC_VGA_16BIT]
            && (TXN_ADDR[15:10] != 6'h00)
        |=> !TXN_CLAIM;
    endproperty
    a_vga_wide: assert property (p_vga_wide)
        else $error("alias claimed in 16-bit decode");

    property p_isa_on;
        TXN_VALID && TXN_IO && bridge_control_q[BC_ISA_BLOCK]
            && (TXN_ADDR[31:16] == 16'h0000)
            && (TXN_ADDR[9:0] >= ISA_ALIAS_LO)
            && (TXN_ADDR[15:0] >= IO_BASE)
            && (TXN_ADDR[15:0] <= IO_LIMIT)
        |=> TXN_BLOCK;
    endproperty
    a_isa_on: assert property (p_isa_on)
        else $error("isa alias not blocked");

    c_hot_cycle: cover property (HOT_RESET ##[1:20] !HOT_RESET);
    c_vga_claim: cover property (TXN_CLAIM);
    c_isa_block: cover property (TXN_BLOCK);
    c_par_race:  cover property (parity_clr && parity_set_w && parity_q);
    c_vga_wide:  cover property (TXN_VALID && TXN_IO
                                 && bridge_control_q[BC_VGA_16BIT]);
endmodule : rprb_top

/* dv/rprb_link_dev.sv */
// behavioural model of the device attached on the express link
`timescale 1ns/1ps
module rprb_link_dev (
    input  wire logic clk,
    input  wire logic hot_reset,
    input  wire logic req_err,
    input  wire logic req_fatal,
    input  wire logic req_poison,
    output logic      err_valid,
    output logic      err_fatal,
    output logic      poison_cpl
);
    // a link held in hot reset carries no traffic, so requests are lost
    always_ff @(posedge clk) begin
        err_valid  <= req_err & ~hot_reset;
        err_fatal  <= req_err & req_fatal & ~hot_reset;
        poison_cpl <= req_poison & ~hot_reset;
    end
endmodule : rprb_link_dev

/* dv/rprb_top_test.sv */
// self-checking bench for bridge control and express capability header
`timescale 1ns/1ps
module rprb_top_test;
    import rprb_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cfg_wr = 1'b0;
    logic        cfg_rd = 1'b0;
    logic [5:0]  cfg_addr = 6'h00;
    logic [3:0]  cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic        txn_valid = 1'b0;
    logic        txn_io = 1'b0;
    logic [31:0] txn_addr = 32'h0;
    logic [15:0] io_base = 16'h0000;
    logic [15:0] io_limit = 16'hFFFF;
    logic        tx_poison = 1'b0;
    logic        req_err = 1'b0;
    logic        req_fatal = 1'b0;
    logic        req_poison = 1'b0;
    logic [31:0] rdata;
    logic        rvalid, hot_reset, txn_done, txn_claim, txn_block;
    logic        fwd_valid, fwd_fatal, parity_det;
    logic        err_valid, err_fatal, poison_cpl;
    int          errors = 0;
    int          checked = 0;

    // 25 MHz core clock
    always #20 clk = ~clk;

    rprb_top rprb_top_i (
        .CORE_CLK(clk), .RST(rst), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd),
        .CFG_ADDR(cfg_addr), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata),
        .CFG_RDATA(rdata), .CFG_RVALID(rvalid), .HOT_RESET(hot_reset),
        .TXN_VALID(txn_valid), .TXN_IO(txn_io), .TXN_ADDR(txn_addr),
        .IO_BASE(io_base), .IO_LIMIT(io_limit), .TXN_DONE(txn_done),
        .TXN_CLAIM(txn_claim), .TXN_BLOCK(txn_block),
        .ERR_MSG_VALID(err_valid), .ERR_MSG_FATAL(err_fatal),
        .ERR_FWD_VALID(fwd_valid), .ERR_FWD_FATAL(fwd_fatal),
        .RX_POISON_CPL(poison_cpl), .TX_POISON_WR(tx_poison),
        .SEC_PARITY_DET(parity_det)
    );

    rprb_link_dev rprb_link_dev_i (
        .clk(clk), .hot_reset(hot_reset), .req_err(req_err),
        .req_fatal(req_fatal), .req_poison(req_poison),
        .err_valid(err_valid), .err_fatal(err_fatal),
        .poison_cpl(poison_cpl)
    );

    // inputs change 1 ns after the edge so no race with sampling
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic wrap_up();
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // leading tick keeps strobes from being set and cleared in one step
    task automatic wr(input logic [5:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        tick();
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        tick();
        cfg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [31:0] exp,
                      input string name);
        tick();
        cfg_rd = 1'b1;
        cfg_addr = a;
        tick();
        cfg_rd = 1'b0;
        chk("read valid", 32'h1, {31'h0, rvalid});
        chk(name, exp, rdata);
    endtask : rd

    task automatic bc(input logic [15:0] v);
        wr(6'h0F, 4'hC, {v, 16'h0000});
    endtask : bc

    task automatic txn(input logic io, input logic [31:0] a,
                       input logic c, input logic b);
        tick();
        txn_valid = 1'b1;
        txn_io = io;
        txn_addr = a;
        tick();
        txn_valid = 1'b0;
        chk("decode done", 32'h1, {31'h0, txn_done});
        chk("claim", {31'h0, c}, {31'h0, txn_claim});
        chk("block", {31'h0, b}, {31'h0, txn_block});
    endtask : txn

    // the link model adds one cycle before the message reaches the port
    task automatic err(input logic fatal, input logic fwd);
        tick();
        req_err = 1'b1;
        req_fatal = fatal;
        tick();
        req_err = 1'b0;
        tick();
        chk("forward valid", {31'h0, fwd}, {31'h0, fwd_valid});
        chk("forward fatal", {31'h0, fwd & fatal}, {31'h0, fwd_fatal});
    endtask : err

    task automatic poison(input logic from_tx, input logic exp);
        tick();
        if (from_tx) begin
            tx_poison = 1'b1;
            tick();
            tx_poison = 1'b0;
        end else begin
            req_poison = 1'b1;
            tick();
            req_poison = 1'b0;
            tick();
        end
        chk("parity flag", {31'h0, exp}, {31'h0, parity_det});
    endtask : poison

    // whole run is about 120 cycles, so 3000 means a hang
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        wrap_up();
    end

    initial begin
        repeat (20) tick();
        rst = 1'b0;
        rd(6'h10, 32'h0041_9010, "cap");
        rd(6'h0F, 32'h0000_0000, "bridge reset value");
        rd(6'h20, 32'h0000_0000, "unmapped read");
        bc(16'hFFFF);
        chk("hot reset", 32'h1, {31'h0, hot_reset});
        rd(6'h0F, 32'h005F_0000, "bridge writable bits");
        bc(16'h0008);
        chk("hot reset", 32'h0, {31'h0, hot_reset});
        txn(1'b0, 32'h000A_0000, 1'b1, 1'b0);
        txn(1'b0, 32'h000B_FFFF, 1'b1, 1'b0);
        txn(1'b0, 32'h000C_0000, 1'b0, 1'b0);
        txn(1'b1, 32'h0000_07C0, 1'b1, 1'b0);
        txn(1'b1, 32'h0000_03BC, 1'b0, 1'b0);
        bc(16'h0018);
        txn(1'b1, 32'h0000_07C0, 1'b0, 1'b0);
        txn(1'b1, 32'h0000_03C0, 1'b1, 1'b0);
        bc(16'h0000);
        txn(1'b0, 32'h000A_0000, 1'b0, 1'b0);
        txn(1'b1, 32'h0000_0500, 1'b0, 1'b0);
        bc(16'h0004);
        txn(1'b1, 32'h0000_0500, 1'b0, 1'b1);
        txn(1'b1, 32'h0000_04FF, 1'b0, 1'b0);
        txn(1'b1, 32'h0001_0500, 1'b0, 1'b0);
        io_base = 16'h0800;
        txn(1'b1, 32'h0000_0500, 1'b0, 1'b0);
        bc(16'h0000);
        for (int f = 0; f < 2; f++) err(f[0], 1'b0);
        poison(1'b0, 1'b0);
        poison(1'b1, 1'b0);
        bc(16'h0003);
        for (int f = 0; f < 2; f++) err(f[0], 1'b1);
        poison(1'b0, 1'b1);
        rd(6'h07, 32'h0100_0000, "secondary status");
        wr(6'h07, 4'h8, 32'h0100_0000);
        chk("parity flag", 32'h0, {31'h0, parity_det});
        poison(1'b1, 1'b1);
        // clear and new event in one cycle: the event must win
        tick();
        cfg_wr = 1'b1;
        cfg_addr = 6'h07;
        cfg_be = 4'h8;
        cfg_wdata = 32'h0100_0000;
        tx_poison = 1'b1;
        tick();
        cfg_wr = 1'b0;
        tx_poison = 1'b0;
        chk("parity race", 32'h1, {31'h0, parity_det});
        wr(6'h07, 4'h8, 32'h0100_0000);
        rd(6'h07, 32'h0000_0000, "secondary status");
        wr(6'h10, 4'h8, 32'hFFFF_FFFF);
        rd(6'h10, 32'h0141_9010, "slot set");
        wr(6'h10, 4'h8, 32'h0000_0000);
        rd(6'h10, 32'h0141_9010, "slot locked");
        // a platform reset mid-run frees the slot bit again
        rst = 1'b1;
        repeat (2) tick();
        rst = 1'b0;
        rd(6'h0F, 32'h0000_0000, "bridge after reset");
        rd(6'h10, 32'h0041_9010, "slot after reset");
        wr(6'h10, 4'h8, 32'h0000_0000);
        wr(6'h10, 4'h8, 32'hFFFF_FFFF);
        rd(6'h10, 32'h0041_9010, "slot kept zero");
        wrap_up();
    end
endmodule : rprb_top_test
